// file: scpc_pkg.sv
/*
 * Package for the peripheral control register bank: offsets, reset
 * values, writable masks, field positions and select codes.
 * Assumes a 32-bit APB slave with 12 address bits.
 */
package scpc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  typedef logic [31:0] scpc_word_t;
  localparam int unsigned  SCPC_AW          = 12;
  localparam logic [11:0]  SCPC_OFS_CLKGATE = 12'h060;
  localparam logic [11:0]  SCPC_OFS_TRIGSEL = 12'h0d0;
  localparam logic [11:0]  SCPC_OFS_DUSEL   = 12'h0d4;
  localparam logic [11:0]  SCPC_OFS_SUSP    = 12'h0d8;
  localparam scpc_word_t   SCPC_RST_CLKGATE = 32'h00000000;
  localparam scpc_word_t   SCPC_RST_TRIGSEL = 32'h00000000;
  localparam scpc_word_t   SCPC_RST_DUSEL   = 32'h04030100;
  localparam scpc_word_t   SCPC_RST_SUSP    = 32'h00000081;
  localparam scpc_word_t   SCPC_MSK_CLKGATE = 32'h0000051f;
  localparam scpc_word_t   SCPC_MSK_TRIGSEL = 32'h0000003f;
  localparam scpc_word_t   SCPC_MSK_DUSEL   = 32'h07070707;
  localparam scpc_word_t   SCPC_MSK_SUSP    = 32'h000006de;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned  SCPC_TS_SRC_W    = 4;
  localparam int unsigned  SCPC_TS_PERSIST  = 4;
  localparam int unsigned  SCPC_TS_ROUTE    = 5;
  localparam int unsigned  SCPC_DU_N        = 4;
  localparam int unsigned  SCPC_DU_W        = 3;
  localparam int unsigned  SCPC_DU_STRIDE   = 8;
  localparam int unsigned  SCPC_CG_T21      = 10;
  localparam int unsigned  SCPC_CG_SYNC_SERIAL_TWO     = 8;
  localparam int unsigned  SCPC_CG_GPT      = 4;
  localparam int unsigned  SCPC_CG_T2       = 3;
  localparam int unsigned  SCPC_CG_CCU      = 2;
  localparam int unsigned  SCPC_CG_SYNC_SERIAL_ONE     = 1;
  localparam int unsigned  SCPC_CG_ADC      = 0;
  localparam int unsigned  SCPC_SU_W        = 11;
  localparam int unsigned  SCPC_SU_ADC      = 10;
  localparam int unsigned  SCPC_SU_MU       = 9;
  localparam int unsigned  SCPC_SU_WDT      = 7;
  localparam int unsigned  SCPC_SU_T21      = 6;
  localparam int unsigned  SCPC_SU_GPT      = 4;
  localparam int unsigned  SCPC_SU_T2       = 3;
  localparam int unsigned  SCPC_SU_T13      = 2;
  localparam int unsigned  SCPC_SU_T12      = 1;

  // ****************************************************************
  // Select codes and timing
  // ****************************************************************
  localparam logic [3:0]   SCPC_SRC_CAP_LAST  = 4'h2;
  localparam logic [3:0]   SCPC_SRC_EVT_FIRST = 4'h3;
  localparam logic [3:0]   SCPC_SRC_EVT_LAST  = 4'ha;
  localparam logic [3:0]   SCPC_SRC_ANY_EDGE  = 4'hb;
  localparam int unsigned  SCPC_SYNC_STAGES   = 3;

endpackage

// file: scpc_ctl_if.sv
/*
 * Control bundle from the register bank to its trigger selector and
 * debug suspend logic. Assumes all ends run on mclk.
 */
`timescale 1ns/1ps
interface scpc_ctl_if;
  import scpc_pkg::*;
  logic [SCPC_TS_SRC_W-1:0] src_sel;
  logic                     persist;
  logic                     route;
  logic [SCPC_SU_W-1:0]     susp_en;
  logic                     halted;
  modport ctrl (output src_sel, persist, route, susp_en, input halted);
  modport trig (input src_sel, persist, route);
  modport susp (input susp_en, output halted);
endinterface

// file: scpc_trig_sel.sv
/*
 * Timer input source selector and capture/compare trigger router.
 * Assumes all event inputs are synchronous to mclk.
 */
`timescale 1ns/1ps
module scpc_trig_sel
  import scpc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Control
  scpc_ctl_if.trig        ctl,
  // Sources
  input  wire logic [2:0] cap_in,
  input  wire logic [7:0] evt_in,
  input  wire logic       t21_trig,
  // Results
  output logic            tin_src,
  output logic            cc_trig
);
  typedef struct packed {
    logic [2:0]               cap;
    logic [SCPC_TS_SRC_W-1:0] sel;
    logic                     src;
    logic                     trig;
  } scpc_trig_st_t;
  scpc_trig_st_t r_ff;
  scpc_trig_st_t nxt_r;
  logic          src;
  logic          edge_hit;

  always_comb begin
    nxt_r = r_ff;
    src = 1'b0;
    if (ctl.src_sel <= SCPC_SRC_CAP_LAST) begin
      src = cap_in[ctl.src_sel[1:0]];
    end else if (ctl.src_sel <= SCPC_SRC_EVT_LAST) begin
      src = evt_in[3'(ctl.src_sel - SCPC_SRC_EVT_FIRST)];
    end else if (ctl.src_sel == SCPC_SRC_ANY_EDGE) begin
      src = |(cap_in ^ r_ff.cap);
    end
    // Edge ignored in the cycle after a select change: no false trigger
    edge_hit = (ctl.src_sel == r_ff.sel) &&
               ((ctl.src_sel == SCPC_SRC_ANY_EDGE) ? src : (src && !r_ff.src));
    nxt_r.cap = cap_in;
    nxt_r.sel = ctl.src_sel;
    nxt_r.src = src;
    if (!ctl.route) begin
      nxt_r.trig = t21_trig;
    end else if (ctl.persist) begin
      nxt_r.trig = r_ff.trig ^ edge_hit;
    end else begin
      nxt_r.trig = edge_hit;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tin_src = r_ff.src;
  assign cc_trig = r_ff.trig;
endmodule

// file: scpc_susp_gate.sv
/*
 * Debug halt synchroniser and per-module timer freeze.
 * Assumes the halt level comes from another clock domain.
 */
`timescale 1ns/1ps
module scpc_susp_gate
  import scpc_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // Control
  scpc_ctl_if.susp                  ctl,
  // Debug
  input  wire logic                 debug_halted,
  output logic [SCPC_SU_W-1:0]      freeze
);
  typedef struct packed {
    logic [SCPC_SYNC_STAGES-1:0] sy;
    logic                        halted;
    logic [SCPC_SU_W-1:0]        frz;
  } scpc_susp_st_t;
  scpc_susp_st_t r_ff;
  scpc_susp_st_t nxt_r;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.sy = {r_ff.sy[1:0], debug_halted};
    // Second and third stage must agree before the level counts
    if (r_ff.sy[1] == r_ff.sy[2]) begin
      nxt_r.halted = r_ff.sy[2];
    end
    // Counter enables drop; T12 and T13 bits also force PWM idle, T12 also disables capture; module clock keeps running
    nxt_r.frz = r_ff.halted ? ctl.susp_en : '0;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign ctl.halted = r_ff.halted;
  assign freeze     = r_ff.frz;
endmodule

// file: scpc_top.sv
/*
 * Peripheral control register bank: timer input and trigger select,
 * differential unit enable select, clock gate requests, debug suspend.
 * Assumes an APB master on mclk and timer events synchronous to mclk.
 */
// Chosen here: register access over APB.
`timescale 1ns/1ps
module scpc_top
  import scpc_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               arst_n,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [SCPC_AW-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Capture/compare unit events
  input  wire logic               cc_channel_0_in,
  input  wire logic               cc_channel_1_in,
  input  wire logic               cc_channel_2_in,
  input  wire logic               t12_zero_match,
  input  wire logic               t12_period_match,
  input  wire logic [2:0]         t12_cmp_match,
  input  wire logic               t13_period_match,
  input  wire logic               t13_zero_match,
  input  wire logic               t13_cmp_match,
  input  wire logic               compare_out_ch0,
  input  wire logic               compare_out_ch1,
  input  wire logic               compare_out_ch2,
  input  wire logic               compare_out_ch3,
  // Other timers
  input  wire logic               gp_timer3_out,
  input  wire logic               t21_event,
  // Trigger results
  output logic                    timer3_input_b,
  output logic                    timer4_input_d,
  output logic                    capcomp_event_trigger,
  // Differential unit enables
  output logic                    diff_unit_en_a,
  output logic                    diff_unit_en_b,
  output logic                    diff_unit_en_c,
  output logic                    diff_unit_en_d,
  // Clock gate requests
  output logic                    timer_twentyone_gate_req,
  output logic                    serial_two_gate_req,
  output logic                    gp_timer_gate_req,
  output logic                    timer_two_gate_req,
  output logic                    capcomp_gate_req,
  output logic                    serial_one_gate_req,
  output logic                    adc_gate_req,
  // Debug suspend
  input  wire logic               debug_halted,
  output logic                    adc_debug_freeze,
  output logic                    measure_debug_freeze,
  output logic                    watchdog_debug_freeze,
  output logic                    timer_twentyone_freeze,
  output logic                    gp_timer_freeze,
  output logic                    timer_two_freeze,
  output logic                    aux_capcomp_freeze,
  output logic                    main_capcomp_freeze,
  output logic                    aux_pwm_force_idle,
  output logic                    main_pwm_force_idle,
  output logic                    main_capture_disable
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    scpc_word_t           clkgate;
    scpc_word_t           trigsel;
    scpc_word_t           dusel;
    scpc_word_t           susp;
    scpc_word_t           rdata;
    logic                 slverr;
    logic [SCPC_DU_N-1:0] du;
  } scpc_st_t;

  localparam scpc_st_t SCPC_ST_RST = '{
    clkgate: SCPC_RST_CLKGATE,
    trigsel: SCPC_RST_TRIGSEL,
    dusel:   SCPC_RST_DUSEL,
    susp:    SCPC_RST_SUSP,
    rdata:   '0,
    slverr:  1'b0,
    du:      '0
  };

  scpc_st_t             r_ff;
  scpc_st_t             nxt_r;
  logic                 setup_ph;
  logic                 access_ph;
  logic                 wr_en;
  scpc_word_t           lane_mask;
  logic [SCPC_DU_N-1:0] du_raw;
  logic [7:0]           du_src;
  logic [SCPC_SU_W-1:0] freeze;
  logic                 tin_src;

  scpc_ctl_if ctl ();

  // Only writable bits change; reserved bits keep reset contents
  function automatic scpc_word_t merge(scpc_word_t old, scpc_word_t wd,
                                      scpc_word_t msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction

  // ****************************************************************
  // APB access
  // ****************************************************************
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en     = access_ph && pwrite && !r_ff.slverr;
  assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    nxt_r = r_ff;
    // Decode in the setup cycle so the access phase needs no wait
    if (setup_ph) begin
      nxt_r.slverr = 1'b0;
      case (paddr)
        SCPC_OFS_CLKGATE: begin
          nxt_r.rdata = r_ff.clkgate;
        end
        SCPC_OFS_TRIGSEL: begin
          nxt_r.rdata = r_ff.trigsel;
        end
        SCPC_OFS_DUSEL: begin
          nxt_r.rdata = r_ff.dusel;
        end
        SCPC_OFS_SUSP: begin
          nxt_r.rdata = r_ff.susp;
        end
        default: begin
          nxt_r.rdata  = '0;
          nxt_r.slverr = 1'b1;
        end
      endcase
    end
    if (wr_en) begin
      case (paddr)
        SCPC_OFS_CLKGATE: begin
          nxt_r.clkgate = merge(r_ff.clkgate, pwdata, lane_mask & SCPC_MSK_CLKGATE);
        end
        SCPC_OFS_TRIGSEL: begin
          nxt_r.trigsel = merge(r_ff.trigsel, pwdata, lane_mask & SCPC_MSK_TRIGSEL);
        end
        SCPC_OFS_DUSEL: begin
          nxt_r.dusel = merge(r_ff.dusel, pwdata, lane_mask & SCPC_MSK_DUSEL);
        end
        SCPC_OFS_SUSP: begin
          nxt_r.susp = merge(r_ff.susp, pwdata, lane_mask & SCPC_MSK_SUSP);
        end
        default: begin
          nxt_r.slverr = r_ff.slverr;
        end
      endcase
    end
    nxt_r.du = du_raw;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= SCPC_ST_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access_ph && r_ff.slverr;
  assign prdata  = r_ff.rdata;

  // ****************************************************************
  // Differential unit enables
  // ****************************************************************
  // Compare output 3 comes from the aux timer used for blanking
  assign du_src = {compare_out_ch3, gp_timer3_out, compare_out_ch2, compare_out_ch1,
                   compare_out_ch0, cc_channel_2_in, cc_channel_1_in, cc_channel_0_in};

  for (genvar g = 0; g < SCPC_DU_N; g++) begin : g_du
    assign du_raw[g] = du_src[r_ff.dusel[g*SCPC_DU_STRIDE +: SCPC_DU_W]];
  end

  assign diff_unit_en_a = r_ff.du[0];
  assign diff_unit_en_b = r_ff.du[1];
  assign diff_unit_en_c = r_ff.du[2];
  assign diff_unit_en_d = r_ff.du[3];

  // ****************************************************************
  // Trigger selection
  // ****************************************************************
  assign ctl.src_sel = r_ff.trigsel[SCPC_TS_SRC_W-1:0];
  assign ctl.persist = r_ff.trigsel[SCPC_TS_PERSIST];
  assign ctl.route   = r_ff.trigsel[SCPC_TS_ROUTE];
  assign ctl.susp_en = r_ff.susp[SCPC_SU_W-1:0];

  scpc_trig_sel u_trig (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .ctl      (ctl),
    .cap_in   ({cc_channel_2_in, cc_channel_1_in, cc_channel_0_in}),
    .evt_in   ({t13_cmp_match, t13_zero_match, t13_period_match, t12_cmp_match,
                t12_period_match, t12_zero_match}),
    .t21_trig (t21_event),
    .tin_src  (tin_src),
    .cc_trig  (capcomp_event_trigger)
  );

  assign timer3_input_b = tin_src;
  assign timer4_input_d = tin_src;

  // ****************************************************************
  // Clock gate requests
  // ****************************************************************
  // Straight from flops: glitch-free for the peripheral's own sync
  assign timer_twentyone_gate_req = r_ff.clkgate[SCPC_CG_T21];
  assign serial_two_gate_req      = r_ff.clkgate[SCPC_CG_SYNC_SERIAL_TWO];
  assign gp_timer_gate_req        = r_ff.clkgate[SCPC_CG_GPT];
  assign timer_two_gate_req       = r_ff.clkgate[SCPC_CG_T2];
  assign capcomp_gate_req         = r_ff.clkgate[SCPC_CG_CCU];
  assign serial_one_gate_req      = r_ff.clkgate[SCPC_CG_SYNC_SERIAL_ONE];
  assign adc_gate_req             = r_ff.clkgate[SCPC_CG_ADC];

  // ****************************************************************
  // Debug suspend
  // ****************************************************************
  scpc_susp_gate u_susp (
    .mclk         (mclk),
    .arst_n       (arst_n),
    .ctl          (ctl),
    .debug_halted (debug_halted),
    .freeze       (freeze)
  );

  assign adc_debug_freeze       = freeze[SCPC_SU_ADC];
  assign measure_debug_freeze   = freeze[SCPC_SU_MU];
  assign watchdog_debug_freeze  = freeze[SCPC_SU_WDT];
  assign timer_twentyone_freeze = freeze[SCPC_SU_T21];
  assign gp_timer_freeze        = freeze[SCPC_SU_GPT];
  assign timer_two_freeze       = freeze[SCPC_SU_T2];
  assign aux_capcomp_freeze     = freeze[SCPC_SU_T13];
  assign main_capcomp_freeze    = freeze[SCPC_SU_T12];
  assign aux_pwm_force_idle     = freeze[SCPC_SU_T13];
  assign main_pwm_force_idle    = freeze[SCPC_SU_T12];
  assign main_capture_disable   = freeze[SCPC_SU_T12];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence clkgate_wr_s;
    psel && penable && pwrite && (paddr == SCPC_OFS_CLKGATE) && pstrb[0];
  endsequence

  sequence gpt_halt_s;
    (debug_halted && r_ff.susp[SCPC_SU_GPT])[*5];
  endsequence

  sequence run_s;
    (!debug_halted)[*5];
  endsequence

  gate_req_write_a: assert property (clkgate_wr_s |=> adc_gate_req == $past(pwdata[0]))
    else $error("gate request did not follow write");

  gate_req_hold_a: assert property (!(psel && penable && pwrite) |=>
      $stable(r_ff.clkgate))
    else $error("gate request changed without write");

  rsvd_read_zero_a: assert property ((setup_ph && paddr == SCPC_OFS_CLKGATE) |=>
      (prdata & ~SCPC_MSK_CLKGATE) == '0)
    else $error("reserved gate bits read nonzero");

  du_select_a: assert property (1'b1 |=> diff_unit_en_a == $past(du_raw[0]))
    else $error("diff enable a wrong source");

  route_t21_a: assert property (!ctl.route |=>
      capcomp_event_trigger == $past(t21_event))
    else $error("trigger not from timer21");

  rsvd_code_quiet_a: assert property ((ctl.route && !ctl.persist && ctl.src_sel >= 4'hc)
      |=> !capcomp_event_trigger)
    else $error("spurious trigger on reserved code");

  persist_hold_a: assert property ((ctl.route && ctl.persist && ctl.src_sel >= 4'hc
      && capcomp_event_trigger) |=> capcomp_event_trigger)
    else $error("persistent trigger dropped");

  tin_follow_a: assert property ((ctl.src_sel == 4'h0) |=>
      timer3_input_b == $past(cc_channel_0_in))
    else $error("timer input not channel 0");

  halt_freeze_a: assert property (gpt_halt_s |=> gp_timer_freeze)
    else $error("timer not frozen while halted");

  run_no_freeze_a: assert property (run_s |=> !gp_timer_freeze && !main_capcomp_freeze)
    else $error("freeze without halt");

  frozen_access_a: assert property ((gp_timer_freeze && psel && penable && pwrite
      && paddr == SCPC_OFS_TRIGSEL && pstrb[0]) |=>
      ctl.src_sel == $past(pwdata[3:0]))
    else $error("register write lost while frozen");

  main_suspend_a: assert property (main_capcomp_freeze |->
      main_pwm_force_idle && main_capture_disable && $past(r_ff.susp[SCPC_SU_T12]))
    else $error("main timer suspend incomplete");

  aux_suspend_a: assert property (aux_capcomp_freeze |->
      aux_pwm_force_idle && $past(r_ff.susp[SCPC_SU_T13]))
    else $error("aux timer suspend incomplete");

endmodule

// file: scpc_bench.sv
/*
 * Self-checking bench for the peripheral control register bank:
 * register access over APB, source selection, gate requests, freeze.
 * Assumes the design package and scpc_top; no other models.
 */
`timescale 1ns/1ps
module scu_peripheral_control_bench;
  import scpc_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, dbg = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, r = 32'h41027621, q, prdata;
  logic [3:0]  pstrb = '0, c, o;
  logic [16:0] ev = '0, pv, ppv;
  logic [6:0]  g;
  logic [10:0] fz;
  logic        pready, pslverr, e, rt, ps, tg, hb;
  logic        pv_aux, pv_main, pv_cap;
  scpc_word_t  mdl [4];
  scpc_word_t  mk [4] = '{SCPC_MSK_CLKGATE, SCPC_MSK_TRIGSEL, SCPC_MSK_DUSEL, SCPC_MSK_SUSP};
  scpc_word_t  rs [4] = '{SCPC_RST_CLKGATE, SCPC_RST_TRIGSEL, SCPC_RST_DUSEL, SCPC_RST_SUSP};
  logic [11:0] ofs [4] = '{SCPC_OFS_CLKGATE, SCPC_OFS_TRIGSEL, SCPC_OFS_DUSEL, SCPC_OFS_SUSP};
  int          errors = 0, comparisons = 0;

  always #5 mclk = ~mclk;

  scpc_top DUT (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cc_channel_0_in(ev[0]), .cc_channel_1_in(ev[1]),
    .cc_channel_2_in(ev[2]), .t12_zero_match(ev[3]), .t12_period_match(ev[4]),
    .t12_cmp_match(ev[7:5]), .t13_period_match(ev[8]), .t13_zero_match(ev[9]),
    .t13_cmp_match(ev[10]), .compare_out_ch0(ev[11]), .compare_out_ch1(ev[12]),
    .compare_out_ch2(ev[13]), .compare_out_ch3(ev[14]), .gp_timer3_out(ev[15]),
    .t21_event(ev[16]), .timer3_input_b(o[0]), .timer4_input_d(o[1]),
    .capcomp_event_trigger(o[2]), .diff_unit_en_a(g[0]), .diff_unit_en_b(g[1]),
    .diff_unit_en_c(g[2]), .diff_unit_en_d(g[3]), .timer_twentyone_gate_req(fz[0]),
    .serial_two_gate_req(fz[1]), .gp_timer_gate_req(fz[2]), .timer_two_gate_req(fz[3]),
    .capcomp_gate_req(fz[4]), .serial_one_gate_req(fz[5]), .adc_gate_req(fz[6]),
    .debug_halted(dbg), .adc_debug_freeze(fz[7]), .measure_debug_freeze(fz[8]),
    .watchdog_debug_freeze(fz[9]), .timer_twentyone_freeze(fz[10]), .gp_timer_freeze(g[4]),
    .timer_two_freeze(g[5]), .aux_capcomp_freeze(g[6]), .main_capcomp_freeze(o[3]),
    .aux_pwm_force_idle(pv_aux), .main_pwm_force_idle(pv_main), .main_capture_disable(pv_cap)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function int du(input logic [2:0] k);
    return k < 3 ? k : (k < 6 ? k + 8 : (k == 6 ? 15 : 14));
  endfunction

  function logic tx(input logic [3:0] k);
    return k < 4'd11 ? pv[k] : (k == 4'hb ? |(pv[2:0] ^ ppv[2:0]) : 1'b0);
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reserved bits keep their reset level, so the model merges that in
  task wr(input int k, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, ofs[k], d, s);
    for (int b = 0; b < 4; b++) if (s[b]) mdl[k][8*b+:8] = d[8*b+:8];
    mdl[k] = (mdl[k] & mk[k]) | (rs[k] & ~mk[k]);
  endtask

  task rd(input int k);
    apb(1'b0, ofs[k], 32'h0, 4'h0);
    chk(q, mdl[k]);
    chk(e, 0);
  endtask

  task results;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #100us;
    errors++;
    results();
  end

  initial begin
    for (int k = 0; k < 4; k++) mdl[k] = rs[k];
    repeat (10) @(posedge mclk);
    chk({fz, g, o}, 0);
    arst_n <= 1'b1;
    for (int k = 0; k < 4; k++) rd(k);
    for (int n = 0; n < 12; n++) begin
      wr(n % 4, r, r[7:4]);
      r = nx(r);
      rd(n % 4);
      chk(fz[6:0], {mdl[0][0], mdl[0][1], mdl[0][2], mdl[0][3], mdl[0][4], mdl[0][8],
                    mdl[0][10]});
    end
    apb(1'b0, 12'h100, 32'h0, 4'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b1, 12'h061, 32'hffffffff, 4'hf);
    chk(e, 1);
    for (int k = 0; k < 4; k++) rd(k);
    // Early cycles after a select change are skipped: edges there are ignored
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      rt = c[0] | (c > 4'd10);
      ps = rt & c[1];
      wr(1, {28'h0, c}, 4'hf);
      // Leaving route 0 loads the trigger with the idle t21 level
      wr(1, {26'h0, rt, ps, c}, 4'hf);
      wr(2, {5'h0, c[2:0] + 3'd3, 5'h0, c[2:0] + 3'd2, 5'h0, c[2:0] + 3'd1, 5'h0, c[2:0]}, 4'hf);
      tg = ev[16];
      for (int j = 0; j < 12; j++) begin
        @(posedge mclk);
        ppv = pv;
        pv = ev;
        ev <= r[16:0];
        r = nx(r);
        @(negedge mclk);
        hb = (j > 0) && ((c == 4'hb) ? tx(c) : tx(c) & ~ppv[c]);
        tg = ps ? tg ^ hb : (rt ? hb : pv[16]);
        if (j > 1) begin
          chk(o[1:0], {2{tx(c)}});
          chk(o[2], tg);
          for (int d = 0; d < 4; d++) chk(g[d], pv[du(c[2:0] + 3'(d))]);
        end
      end
    end
    wr(3, r, 4'hf);
    @(posedge mclk);
    dbg <= 1'b1;
    for (int h = 0; h < 2; h++) begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      chk({pv_aux, pv_cap, pv_main, fz[10:7], g[6:4], o[3]}, {mdl[3][2], mdl[3][1], mdl[3][1],
          mdl[3][6], mdl[3][7], mdl[3][9], mdl[3][10], mdl[3][2], mdl[3][3], mdl[3][4],
          mdl[3][1]});
      wr(1, r, 4'h1);
      rd(1);
      wr(3, ~mdl[3], 4'hf);
    end
    dbg <= 1'b0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk({pv_aux, pv_cap, pv_main, fz[10:7], g[6:4], o[3]}, 0);
    rd(3);
    results();
  end
endmodule
